// ===== shared/rjla_map.svh
`ifndef RJLA_MAP_SVH
`define RJLA_MAP_SVH

// bus geometry
`define RJLA_ADDR_W 12
`define RJLA_DATA_W 32

// array geometry
`define RJLA_N_DED 4
`define RJLA_N_BIO 4
`define RJLA_N_REG 8
`define RJLA_N_VARS 24
`define RJLA_N_LOGIC 32
`define RJLA_N_TERMS 49
`define RJLA_MASK_W 49
`define RJLA_N_OR 21

// product term indices
`define RJLA_T_LOAD0 32
`define RJLA_T_DIR0 40
`define RJLA_T_FOLD 44
`define RJLA_T_SET_LO 45
`define RJLA_T_CLR_LO 46
`define RJLA_T_SET_HI 47
`define RJLA_T_CLR_HI 48

// or gate indices
`define RJLA_OR_BIO0 0
`define RJLA_OR_J0 4
`define RJLA_OR_K0 12
`define RJLA_OR_CNOR 20

// and mask field: bit of the complemented feedback literal
`define RJLA_MASK_CBAR_BIT 48

// register byte offsets
`define RJLA_AND_END 12'h188
`define RJLA_OR_BASE 12'h200
`define RJLA_OR_END 12'h254
`define RJLA_POL_OFS 12'h300
`define RJLA_MODE_OFS 12'h304
`define RJLA_OECFG_OFS 12'h308
`define RJLA_STATUS_OFS 12'h30c

// reset values (unprogrammed device)
`define RJLA_AND_RST 49'h1_ffff_ffff_ffff
`define RJLA_OR_RST 32'hffff_ffff
`define RJLA_POL_RST 4'h0
`define RJLA_MODE_RST 16'h0000
`define RJLA_OECFG_RST 8'hff

// status fields
`define RJLA_STAT_Q_LSB 0
`define RJLA_STAT_BOUT_LSB 8
`define RJLA_STAT_BOE_LSB 12
`define RJLA_STAT_FOE_LSB 16
`define RJLA_STAT_CNOR_BIT 24

// bus responses
`define RJLA_RESP_OKAY 2'h0
`define RJLA_RESP_SLVERR 2'h2

`endif

// ===== shared/rjla_pkg.sv
`default_nettype none
`include "rjla_map.svh"

package rjla_pkg;

  // axi4-lite master to slave
  typedef struct packed {
    logic [`RJLA_ADDR_W-1:0] awaddr;
    logic [2:0] awprot;
    logic awvalid;
    logic [`RJLA_DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [`RJLA_ADDR_W-1:0] araddr;
    logic [2:0] arprot;
    logic arvalid;
    logic rready;
  } rjla_axil_req_s;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic arready;
    logic [`RJLA_DATA_W-1:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
  } rjla_axil_rsp_s;

  // per flip-flop behaviour; code 3 acts as j-k
  typedef enum logic [1:0] {
    RJLA_FF_D = 2'h0,
    RJLA_FF_JK = 2'h1,
    RJLA_FF_FOLD = 2'h2
  } rjla_ffmode_e;

  typedef logic [`RJLA_MASK_W-1:0] rjla_and_mask_t;

endpackage : rjla_pkg

`default_nettype wire

// ===== core/rjla_top.sv
// Operation
// [RULE1] eight registered two-way pins and four combinational two-way lines
// [RULE2] array holds 32 logic terms, 13 control terms, 21 or gates, all selectable; the code has 17 control terms (terms 32 to 48)
// [RULE3] each term takes true or complement of inputs, pins, states, plus feedback complement
// [RULE4] negated term sum is a nor of chosen terms fed back to every term
// [RULE5] each combinational line has a selectable xor for and-or or and-nor output
// [RULE6] j and k of each flip-flop are ors of chosen logic terms
// [RULE7] four dedicated terms drive asynchronous set and clear; the code applies set and clear only at the rising clock edge
// [RULE8] flip-flops change only on the rising clock edge
// [RULE9] flip-flop acts as j-k, toggle or d; jk truth table hold clear set toggle
// [RULE10] fold control term turns a j-k flip-flop into d behaviour at run time
// [RULE11] load term, steering inputs and output gating choose input, output or both roles
// [RULE12] registered pins are three-state, off while output enable high, enable programmable
// [RULE13] set and clear together give high; after release the later-released one rules
// [RULE14] preload: pins driven, outputs off, load term high, clock loads pin complement
// [RULE15] outside party keeps the target flip-flop terms low during preload
// [RULE16] diagnostic level loads every flip-flop from its pin and floats combinational lines
// [RULE17] after power-up each registered pin reads one
// [RULE18] unprogrammed: output enable active, set and clear off, transition terms off
// [RULE19] default d flip-flops, combinational pins inputs, registered pins outputs
// [RULE20] set alone forces high, clear alone forces low, regardless of clock or load; the code applies them at the rising clock edge, ahead of load
// [RULE21] an enabled registered pin drives the complement of its flip-flop state
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`default_nettype none
`include "rjla_map.svh"

module rjla_top (
  // clock and power-on reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // configuration bus
  input wire rjla_pkg::rjla_axil_req_s axi_req_i,
  output rjla_pkg::rjla_axil_rsp_s axi_rsp_o,
  // dedicated inputs and enables
  input wire logic [`RJLA_N_DED-1:0] ded_in_i,
  input wire logic oe_n_i,
  input wire logic diag_i,
  // combinational two-way lines
  input wire logic [`RJLA_N_BIO-1:0] b_in_i,
  output logic [`RJLA_N_BIO-1:0] b_out_o,
  output logic [`RJLA_N_BIO-1:0] b_oe_o,
  // registered two-way pins
  input wire logic [`RJLA_N_REG-1:0] f_in_i,
  output logic [`RJLA_N_REG-1:0] f_out_o,
  output logic [`RJLA_N_REG-1:0] f_oe_o
);
  import rjla_pkg::*;

  // configuration store
  rjla_and_mask_t and_mask_r [0:`RJLA_N_TERMS-1];
  rjla_and_mask_t and_mask_nxt [0:`RJLA_N_TERMS-1];
  logic [31:0] or_mask_r [0:`RJLA_N_OR-1];
  logic [31:0] or_mask_nxt [0:`RJLA_N_OR-1];
  logic [3:0] pol_r, pol_nxt;
  logic [15:0] mode_r, mode_nxt;
  logic [7:0] oecfg_r, oecfg_nxt;

  // bus write side
  logic awready_r, awready_nxt;
  logic wready_r, wready_nxt;
  logic aw_full_r, aw_full_nxt;
  logic w_full_r, w_full_nxt;
  logic [`RJLA_ADDR_W-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic do_write;
  logic wr_hit;
  logic [`RJLA_ADDR_W-1:0] wa;

  // bus read side
  logic arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic [31:0] rd_data;
  logic rd_hit;
  logic [`RJLA_ADDR_W-1:0] ra;

  // array signals
  logic [`RJLA_N_VARS-1:0] vars;
  logic [2*`RJLA_N_VARS-1:0] lits;
  logic [`RJLA_N_TERMS-1:0] pre_term;
  logic [`RJLA_N_TERMS-1:0] term;
  logic [`RJLA_N_OR-1:0] sum;
  logic cnor;

  // device state and pins
  logic [`RJLA_N_REG-1:0] q_r, q_nxt;
  logic [`RJLA_N_REG-1:0] f_out_r, f_out_nxt;
  logic [`RJLA_N_REG-1:0] f_oe_r, f_oe_nxt;
  logic [`RJLA_N_BIO-1:0] b_out_r, b_out_nxt;
  logic [`RJLA_N_BIO-1:0] b_oe_r, b_oe_nxt;

  // byte-lane merge of a written word
  function automatic logic [31:0] merge_word(input logic [31:0] old_w, input logic [31:0] new_w,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_w;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    return res;
  endfunction : merge_word

  // write channel acceptance and response
  always_comb begin
    aw_full_nxt = aw_full_r;
    w_full_nxt = w_full_r;
    awaddr_nxt = awaddr_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    do_write = 1'b0;
    if (awready_r && axi_req_i.awvalid) begin
      aw_full_nxt = 1'b1;
      awaddr_nxt = axi_req_i.awaddr;
    end
    if (wready_r && axi_req_i.wvalid) begin
      w_full_nxt = 1'b1;
      wdata_nxt = axi_req_i.wdata;
      wstrb_nxt = axi_req_i.wstrb;
    end
    if (bvalid_r && axi_req_i.bready) begin
      bvalid_nxt = 1'b0;
    end
    if (aw_full_r && w_full_r && !bvalid_r) begin
      do_write = 1'b1;
      aw_full_nxt = 1'b0;
      w_full_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = wr_hit ? `RJLA_RESP_OKAY : `RJLA_RESP_SLVERR;
    end
    awready_nxt = ~aw_full_nxt;
    wready_nxt = ~w_full_nxt;
  end

  // write decode into the configuration store
  always_comb begin
    wa = {awaddr_r[`RJLA_ADDR_W-1:2], 2'h0};
    for (int t = 0; t < `RJLA_N_TERMS; t++) begin
      and_mask_nxt[t] = and_mask_r[t];
    end
    for (int g = 0; g < `RJLA_N_OR; g++) begin
      or_mask_nxt[g] = or_mask_r[g];
    end
    pol_nxt = pol_r;
    mode_nxt = mode_r;
    oecfg_nxt = oecfg_r;
    wr_hit = 1'b1;
    if (wa < `RJLA_AND_END) begin
      if (do_write && wa[2]) begin // [RULE2] [RULE3]
        and_mask_nxt[wa[8:3]][48:32] = 17'(merge_word({15'h0, and_mask_r[wa[8:3]][48:32]}, wdata_r, wstrb_r));
      end else if (do_write) begin
        and_mask_nxt[wa[8:3]][31:0] = merge_word(and_mask_r[wa[8:3]][31:0], wdata_r, wstrb_r);
      end
    end else if (wa >= `RJLA_OR_BASE && wa < `RJLA_OR_END) begin
      if (do_write) begin // [RULE2]
        or_mask_nxt[wa[6:2]] = merge_word(or_mask_r[wa[6:2]], wdata_r, wstrb_r);
      end
    end else begin
      case (wa)
        `RJLA_POL_OFS: begin
          if (do_write) pol_nxt = 4'(merge_word({28'h0, pol_r}, wdata_r, wstrb_r)); // [RULE5]
        end
        `RJLA_MODE_OFS: begin
          if (do_write) mode_nxt = 16'(merge_word({16'h0, mode_r}, wdata_r, wstrb_r)); // [RULE9]
        end
        `RJLA_OECFG_OFS: begin
          if (do_write) oecfg_nxt = 8'(merge_word({24'h0, oecfg_r}, wdata_r, wstrb_r)); // [RULE12]
        end
        `RJLA_STATUS_OFS: begin
        end
        default: begin
          wr_hit = 1'b0;
        end
      endcase
    end
  end

  // read decode
  always_comb begin
    ra = {axi_req_i.araddr[`RJLA_ADDR_W-1:2], 2'h0};
    rd_data = 32'h0;
    rd_hit = 1'b1;
    if (ra < `RJLA_AND_END) begin
      if (ra[2]) begin
        rd_data = {15'h0, and_mask_r[ra[8:3]][48:32]};
      end else begin
        rd_data = and_mask_r[ra[8:3]][31:0];
      end
    end else if (ra >= `RJLA_OR_BASE && ra < `RJLA_OR_END) begin
      rd_data = or_mask_r[ra[6:2]];
    end else begin
      case (ra)
        `RJLA_POL_OFS: rd_data = {28'h0, pol_r};
        `RJLA_MODE_OFS: rd_data = {16'h0, mode_r};
        `RJLA_OECFG_OFS: rd_data = {24'h0, oecfg_r};
        `RJLA_STATUS_OFS: begin
          rd_data[`RJLA_STAT_Q_LSB +: 8] = q_r;
          rd_data[`RJLA_STAT_BOUT_LSB +: 4] = b_out_r;
          rd_data[`RJLA_STAT_BOE_LSB +: 4] = b_oe_r;
          rd_data[`RJLA_STAT_FOE_LSB +: 8] = f_oe_r;
          rd_data[`RJLA_STAT_CNOR_BIT] = cnor;
        end
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // read channel acceptance and response
  always_comb begin
    arready_nxt = arready_r;
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && axi_req_i.rready) begin
      rvalid_nxt = 1'b0;
      arready_nxt = 1'b1;
    end
    if (arready_r && axi_req_i.arvalid) begin
      arready_nxt = 1'b0;
      rvalid_nxt = 1'b1;
      rdata_nxt = rd_data;
      rresp_nxt = rd_hit ? `RJLA_RESP_OKAY : `RJLA_RESP_SLVERR;
    end
  end

  // bus registers
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      awready_r <= 1'b1;
      wready_r <= 1'b1;
      aw_full_r <= 1'b0;
      w_full_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= `RJLA_RESP_OKAY;
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= `RJLA_RESP_OKAY;
    end else begin
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      aw_full_r <= aw_full_nxt;
      w_full_r <= w_full_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  // configuration registers; reset gives the unprogrammed pattern
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int t = 0; t < `RJLA_N_TERMS; t++) begin
        and_mask_r[t] <= `RJLA_AND_RST; // [RULE18]
      end
      for (int g = 0; g < `RJLA_N_OR; g++) begin
        or_mask_r[g] <= `RJLA_OR_RST;
      end
      pol_r <= `RJLA_POL_RST;
      mode_r <= `RJLA_MODE_RST; // [RULE19]
      oecfg_r <= `RJLA_OECFG_RST; // [RULE18]
    end else begin
      for (int t = 0; t < `RJLA_N_TERMS; t++) begin
        and_mask_r[t] <= and_mask_nxt[t];
      end
      for (int g = 0; g < `RJLA_N_OR; g++) begin
        or_mask_r[g] <= or_mask_nxt[g];
      end
      pol_r <= pol_nxt;
      mode_r <= mode_nxt;
      oecfg_r <= oecfg_nxt;
    end
  end

  // and array: a set mask bit connects a literal, all connected gives a dead term
  always_comb begin
    vars = {q_r, f_in_i, b_in_i, ded_in_i}; // [RULE3]
    lits = {~vars, vars};
    for (int t = 0; t < `RJLA_N_TERMS; t++) begin
      pre_term[t] = &(~and_mask_r[t][2*`RJLA_N_VARS-1:0] | lits); // [RULE3]
    end
    // feedback nor sees terms without their own feedback literal, avoiding a loop
    cnor = ~|(pre_term[`RJLA_N_LOGIC-1:0] & or_mask_r[`RJLA_OR_CNOR]); // [RULE4]
    for (int t = 0; t < `RJLA_N_TERMS; t++) begin
      term[t] = pre_term[t] & (~and_mask_r[t][`RJLA_MASK_CBAR_BIT] | ~cnor); // [RULE4]
    end
    for (int g = 0; g < `RJLA_N_OR; g++) begin
      sum[g] = |(term[`RJLA_N_LOGIC-1:0] & or_mask_r[g]); // [RULE2] [RULE6]
    end
  end

  // flip-flop next state, load paths and pin drive
  always_comb begin
    logic j;
    logic k;
    logic set_a;
    logic clr_a;
    rjla_ffmode_e md;
    j = 1'b0;
    k = 1'b0;
    set_a = 1'b0;
    clr_a = 1'b0;
    md = RJLA_FF_D;
    for (int n = 0; n < `RJLA_N_REG; n++) begin
      j = sum[`RJLA_OR_J0 + n]; // [RULE6]
      k = sum[`RJLA_OR_K0 + n];
      md = rjla_ffmode_e'(mode_r[2*n +: 2]);
      if (md == RJLA_FF_D || (md == RJLA_FF_FOLD && term[`RJLA_T_FOLD])) begin
        k = ~j; // [RULE10] [RULE19]
      end
      set_a = (n < 4) ? term[`RJLA_T_SET_LO] : term[`RJLA_T_SET_HI]; // [RULE7]
      clr_a = (n < 4) ? term[`RJLA_T_CLR_LO] : term[`RJLA_T_CLR_HI];
      if (diag_i) begin
        q_nxt[n] = ~f_in_i[n]; // [RULE16]
      end else if (set_a) begin
        q_nxt[n] = 1'b1; // [RULE13] [RULE20]
      end else if (clr_a) begin
        q_nxt[n] = 1'b0; // [RULE20]
      end else if (term[`RJLA_T_LOAD0 + n]) begin
        q_nxt[n] = ~f_in_i[n]; // [RULE11] [RULE14]
      end else begin
        case ({j, k}) // [RULE9]
          2'b00: q_nxt[n] = q_r[n];
          2'b01: q_nxt[n] = 1'b0;
          2'b10: q_nxt[n] = 1'b1;
          2'b11: q_nxt[n] = ~q_r[n];
          default: q_nxt[n] = q_r[n];
        endcase
      end
    end
    f_out_nxt = ~q_nxt; // [RULE21]
    f_oe_nxt = oecfg_r & {`RJLA_N_REG{~oe_n_i & ~diag_i}}; // [RULE12] [RULE11]
    for (int m = 0; m < `RJLA_N_BIO; m++) begin
      b_out_nxt[m] = sum[`RJLA_OR_BIO0 + m] ^ pol_r[m]; // [RULE5]
      b_oe_nxt[m] = term[`RJLA_T_DIR0 + m] & ~diag_i; // [RULE1] [RULE16] [RULE19]
    end
  end

  // device state and pin registers, all on the rising edge
  always_ff @(posedge clk_i or negedge resetn_i) begin // [RULE8]
    if (!resetn_i) begin
      q_r <= '0; // [RULE17]
      f_out_r <= '1; // [RULE17]
      f_oe_r <= '0;
      b_out_r <= '0;
      b_oe_r <= '0;
    end else begin
      q_r <= q_nxt;
      f_out_r <= f_out_nxt;
      f_oe_r <= f_oe_nxt;
      b_out_r <= b_out_nxt;
      b_oe_r <= b_oe_nxt;
    end
  end

  // outputs straight from flops
  assign b_out_o = b_out_r;
  assign b_oe_o = b_oe_r;
  assign f_out_o = f_out_r;
  assign f_oe_o = f_oe_r;
  assign axi_rsp_o.awready = awready_r;
  assign axi_rsp_o.wready = wready_r;
  assign axi_rsp_o.bresp = bresp_r;
  assign axi_rsp_o.bvalid = bvalid_r;
  assign axi_rsp_o.arready = arready_r;
  assign axi_rsp_o.rdata = rdata_r;
  assign axi_rsp_o.rresp = rresp_r;
  assign axi_rsp_o.rvalid = rvalid_r;

endmodule : rjla_top

`default_nettype wire

// ===== dv/rjla_top_props.sv
`default_nettype none
`include "rjla_map.svh"
module rjla_top_props
  import rjla_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic resetn_i,
  // register bus
  input wire rjla_pkg::rjla_axil_req_s axi_req_i,
  input wire rjla_pkg::rjla_axil_rsp_s axi_rsp_o,
  // enables and pins
  input wire logic oe_n_i,
  input wire logic diag_i,
  input wire logic [`RJLA_N_BIO-1:0] b_oe_o,
  input wire logic [`RJLA_N_REG-1:0] f_in_i,
  input wire logic [`RJLA_N_REG-1:0] f_out_o,
  input wire logic [`RJLA_N_REG-1:0] f_oe_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  // address and data taken at one edge, response follows
  sequence wr_taken;
    axi_req_i.awvalid && axi_rsp_o.awready && axi_req_i.wvalid && axi_rsp_o.wready;
  endsequence
  sequence wr_answer;
    ##[1:2] axi_rsp_o.bvalid;
  endsequence

  // pin and bus behaviour
  chk_pins_after_reset: assert property (!$past(resetn_i) |-> f_out_o == 8'hff && b_oe_o == 4'h0)
    else $error("pins not idle after reset");
  chk_diag_floats: assert property (diag_i |=> b_oe_o == 4'h0)
    else $error("b lines driven in diagnostic mode");
  chk_diag_loads: assert property (diag_i |=> f_out_o == $past(f_in_i))
    else $error("diagnostic load wrong");
  chk_oe_off: assert property ((oe_n_i || diag_i) |=> f_oe_o == 8'h00)
    else $error("registered pins driven while disabled");
  chk_write_answer: assert property (wr_taken |-> wr_answer)
    else $error("write response late");
  chk_bresp_holds: assert property (axi_rsp_o.bvalid && !axi_req_i.bready |=> axi_rsp_o.bvalid && $stable(axi_rsp_o.bresp))
    else $error("write response dropped");
  chk_rdata_holds: assert property (axi_rsp_o.rvalid && !axi_req_i.rready |=> axi_rsp_o.rvalid && $stable(axi_rsp_o.rdata))
    else $error("read data dropped");
  chk_read_answer: assert property (axi_req_i.arvalid && axi_rsp_o.arready |=> axi_rsp_o.rvalid)
    else $error("read answer late");
  chk_arready_busy: assert property (axi_rsp_o.rvalid |-> !axi_rsp_o.arready)
    else $error("read accepted while busy");
endmodule : rjla_top_props

bind rjla_top rjla_top_props i_rjla_top_props (.clk_i, .resetn_i, .axi_req_i, .axi_rsp_o, .oe_n_i, .diag_i,
  .b_oe_o, .f_in_i, .f_out_o, .f_oe_o);
`default_nettype wire

// ===== dv/rjla_board.sv
`default_nettype none
module rjla_board (
  // device side
  input wire logic [7:0] f_out_i,
  input wire logic [7:0] f_oe_i,
  input wire logic [3:0] b_out_i,
  input wire logic [3:0] b_oe_i,
  // board drivers
  input wire logic [7:0] drv_f_i,
  input wire logic [7:0] drv_f_en_i,
  input wire logic [3:0] drv_b_i,
  input wire logic [3:0] drv_b_en_i,
  // resolved levels
  output logic [7:0] f_lvl_o,
  output logic [3:0] b_lvl_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // enabled device wins, then board driver, else pull-up
  assign f_lvl_o = (f_oe_i & f_out_i) | (~f_oe_i & (~drv_f_en_i | drv_f_i));
  assign b_lvl_o = (b_oe_i & b_out_i) | (~b_oe_i & (~drv_b_en_i | drv_b_i));
endmodule : rjla_board
`default_nettype wire

// ===== dv/test_rjla_top.sv
`default_nettype none
`include "rjla_map.svh"
module test_rjla_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rjla_pkg::*;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  rjla_axil_req_s req;
  rjla_axil_rsp_s rsp;
  logic [3:0] ded = 4'h0, b_in, b_out, b_oe, drv_b = 4'h0, drv_b_en = 4'h0;
  logic [7:0] f_in, f_out, f_oe, drv_f = 8'h00, drv_f_en = 8'h00;
  logic oe_n = 1'b0;
  logic diag = 1'b0;
  logic [31:0] rdat;
  logic [1:0] resp;
  logic v;
  int err_total = 0;
  int checks_done = 0;
  int cyc = 0;

  rjla_top i_rjla_top (.clk_i, .resetn_i, .axi_req_i(req), .axi_rsp_o(rsp), .ded_in_i(ded), .oe_n_i(oe_n),
    .diag_i(diag), .b_in_i(b_in), .b_out_o(b_out), .b_oe_o(b_oe), .f_in_i(f_in), .f_out_o(f_out), .f_oe_o(f_oe));
  rjla_board i_rjla_board (.f_out_i(f_out), .f_oe_i(f_oe), .b_out_i(b_out), .b_oe_i(b_oe), .drv_f_i(drv_f),
    .drv_f_en_i(drv_f_en), .drv_b_i(drv_b), .drv_b_en_i(drv_b_en), .f_lvl_o(f_in), .b_lvl_o(b_in));

  // clock and hang guard
  always #5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  task automatic final_report;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask : tick

  // bus write: hold each channel until taken, then wait for the response
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    req.awaddr <= a;
    req.wdata <= d;
    req.awvalid <= 1'b1;
    req.wvalid <= 1'b1;
    @(posedge clk_i);
    while (req.awvalid || req.wvalid) begin
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
      @(posedge clk_i);
    end
    while (!rsp.bvalid) @(posedge clk_i);
    resp = rsp.bresp;
  endtask : wr

  task automatic rd(input logic [11:0] a);
    req.araddr <= a;
    req.arvalid <= 1'b1;
    @(posedge clk_i);
    while (!rsp.arready) @(posedge clk_i);
    req.arvalid <= 1'b0;
    while (!rsp.rvalid) @(posedge clk_i);
    rdat = rsp.rdata;
    resp = rsp.rresp;
  endtask : rd

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    rd(a);
    chk(rdat, e);
  endtask : rchk

  task automatic term(input int t, input rjla_and_mask_t m);
    wr(12'(t * 8), m[31:0]);
    wr(12'(t * 8 + 4), {15'h0, m[48:32]});
  endtask : term

  task automatic pins(input logic [3:0] d, input logic [3:0] b, input logic [7:0] m, input logic [7:0] e);
    ded <= d;
    drv_b <= b;
    tick(2);
    chk(f_out & m, e);
  endtask : pins

  task automatic t_reset;
    tick(2);
    chk(f_out, 8'hff);
    chk(f_oe, 8'hff);
    chk(b_oe, 4'h0);
    rchk(`RJLA_MODE_OFS, 32'h0);
    rchk(`RJLA_OECFG_OFS, 32'hff);
    rchk(12'h168, 32'hffffffff);
    rd(12'h3f0);
    chk(resp, `RJLA_RESP_SLVERR);
    wr(12'h3f4, 32'h0);
    chk(resp, `RJLA_RESP_SLVERR);
    wr(`RJLA_STATUS_OFS, 32'h0);
    chk(resp, `RJLA_RESP_OKAY);
  endtask : t_reset

  // line 1 enable: complemented feedback and complemented ded[1]
  task automatic t_comb;
    term(0, 49'h1);
    term(40, 49'h0);
    term(41, 49'h1_0000_0200_0000);
    wr(`RJLA_OR_BASE, 32'h1);
    ded <= 4'h1;
    tick(2);
    chk(b_oe, 4'h3);
    chk(b_out[0], 1'b1);
    rd(`RJLA_STATUS_OFS);
    chk(rdat[24], 1'b0);
    wr(`RJLA_POL_OFS, 32'h1);
    tick(2);
    chk(b_out[0], 1'b0);
    ded <= 4'h3;
    tick(2);
    chk(b_oe, 4'h1);
    ded <= 4'h0;
    tick(2);
    chk(b_out[0], 1'b1);
    chk(b_oe, 4'h1);
    rd(`RJLA_STATUS_OFS);
    chk(rdat[24], 1'b1);
  endtask : t_comb

  task automatic t_flop;
    term(1, 49'h2);
    term(2, 49'h4);
    term(44, 49'h8);
    wr(`RJLA_OR_BASE + 12'h10, 32'h2);
    wr(`RJLA_OR_BASE + 12'h30, 32'h4);
    pins(4'h2, 4'h0, 8'h01, 8'h00);
    pins(4'h0, 4'h0, 8'h01, 8'h01);
    wr(`RJLA_MODE_OFS, 32'h1);
    pins(4'h2, 4'h0, 8'h01, 8'h00);
    pins(4'h0, 4'h0, 8'h01, 8'h00);
    pins(4'h4, 4'h0, 8'h01, 8'h01);
    ded <= 4'h6;
    tick(2);
    v = f_out[0];
    tick(1);
    chk(f_out[0], {31'h0, ~v});
    wr(`RJLA_MODE_OFS, 32'h2);
    pins(4'h2, 4'h0, 8'h01, 8'h00);
    pins(4'h8, 4'h0, 8'h01, 8'h01);
    pins(4'h2, 4'h0, 8'h01, 8'h00);
    pins(4'h0, 4'h0, 8'h01, 8'h00);
  endtask : t_flop

  task automatic t_setclr;
    wr(`RJLA_MODE_OFS, 32'h0);
    term(45, 49'h40);
    term(46, 49'h80);
    drv_b_en <= 4'hc;
    pins(4'h0, 4'h4, 8'hff, 8'hf0);
    pins(4'h0, 4'hc, 8'hff, 8'hf0);
    pins(4'h0, 4'h8, 8'hff, 8'hff);
    pins(4'h0, 4'h0, 8'hff, 8'hff);
  endtask : t_setclr

  // outputs go off and the board drives before the load term comes alive
  task automatic t_preload;
    oe_n <= 1'b1;
    drv_f_en <= 8'hff;
    term(32, 49'h0);
    pins(4'h0, 4'h0, 8'h03, 8'h02);
    chk(f_oe, 8'h00);
    oe_n <= 1'b0;
    drv_f_en <= 8'h00;
    wr(`RJLA_OECFG_OFS, 32'hfe);
    tick(2);
    chk(f_oe, 8'hfe);
  endtask : t_preload

  // first edge still sees the pins driven by the device, second the board value
  task automatic t_diag;
    diag <= 1'b1;
    drv_f_en <= 8'hff;
    drv_f <= 8'h5a;
    tick(3);
    chk(f_out, 8'h5a);
    chk(b_oe, 4'h0);
    diag <= 1'b0;
  endtask : t_diag

  // reset, then scenarios in turn
  initial begin
    req = '0;
    req.wstrb = 4'hf;
    req.bready = 1'b1;
    req.rready = 1'b1;
    repeat (16) @(posedge clk_i);
    resetn_i <= 1'b1;
    t_reset();
    t_comb();
    t_flop();
    t_setclr();
    t_preload();
    t_diag();
    final_report();
  end
endmodule : test_rjla_top
`default_nettype wire
